// *** rtl/urx_defines.vh ***
// Register offsets, field positions, reset values and encodings of the register map block
`ifndef URX_DEFINES_VH
`define URX_DEFINES_VH
`define URX_ADDR_W          3
`define URX_A_DATA          3'h0
`define URX_A_MASK          3'h1
`define URX_A_SRC           3'h2
`define URX_A_FMT           3'h3
`define URX_A_MCTL          3'h4
`define URX_A_LINE          3'h5
`define URX_A_MODEM         3'h6
`define URX_A_SCRATCH       3'h7
`define URX_ENH_KEY         8'hbf
`define URX_FMT_DIVEN       7
`define URX_EFR_ENH         4
`define URX_FCR_RXEN        0
`define URX_FCR_RXRST       1
`define URX_MASK_RX         0
`define URX_MASK_TX         1
`define URX_MASK_LINE       2
`define URX_MASK_MODEM      3
`define URX_LOW_NIBBLE      8'h0f
`define URX_UPPER_MCTL      8'he0
`define URX_DLD_MASK        8'h3f
`define URX_RESET_BYTE      8'h00
`define URX_SRC_NONE        8'h01
`define URX_SRC_LINE        8'h06
`define URX_SRC_RXDATA      8'h04
`define URX_SRC_TX          8'h02
`define URX_SRC_MODEM       8'h00
`define URX_SRC_FIFO_ON     8'hc0
`define URX_TRIG_1          5'h01
`define URX_TRIG_4          5'h04
`define URX_TRIG_8          5'h08
`define URX_TRIG_14         5'h0e
`define URX_DIV_ZERO        16'h0000
`define URX_NIBBLE_ZERO     4'h0
`define URX_FCR_WR_ENH      8'hf9
`define URX_FCR_WR_STD      8'hc9
`define URX_SRC_STD         8'hcf
`endif

// *** rtl/urx_regmap.v ***
// Upper register map and receive-FIFO interrupt / data-ready logic of one channel
// Summary of operation
// - Mask gates rx, tx, line, modem interrupts
// - Source register reports highest unmasked pending interrupt
// - FIFO and rx mask on: trigger drives source
// - Interrupt raised when fill reaches trigger
// - Interrupt dropped when fill below trigger
// - Source bit and output clear together
// - Data-ready sets when character enters FIFO
// - Data-ready clears only when FIFO empty
// - Enhanced fields writable only with enhance bit
// - Mask register at 001 when divisor bit 0
// - 010 reads source, writes FIFO control
// - Line status read-only at 101 unless key
`default_nettype none
`include "urx_defines.vh"
module urx_regmap #(
    parameter DEPTH     = 16,
    parameter CNT_W     = 5,
    parameter [7:0] REV_CODE = 8'h01, // Arbitrary value
    parameter [7:0] DEV_ID   = 8'h5a  // Arbitrary value
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [2:0]  addr,
    input  wire        cs,
    input  wire        rd,
    input  wire        wr,
    input  wire [7:0]  wdata,
    output reg  [7:0]  rdata,
    input  wire        rxValid,
    output wire        rxReady,
    input  wire [7:0]  rxChar,
    input  wire        txEmpty,
    input  wire        lineEvent,
    input  wire [7:0]  modemStatus,
    output wire        irq,
    output reg  [7:0]  divisorLow,
    output reg  [7:0]  divisorHigh,
    output reg  [7:0]  divisorFraction,
    output reg  [7:0]  enhancedFeature,
    output reg  [7:0]  modemCtrl,
    output reg  [7:0]  lineFormat
);
////////////////////////////////////////////////////////////////////////////////
// Depth as a count-wide constant, so the full compare has no width mismatch
localparam [CNT_W-1:0] DEPTH_C = DEPTH;

////////////////////////////////////////////////////////////////////////////////
// Identity codes replace the divisor bytes only while the whole divisor is zero
function divisor_is_zero;
    input [7:0] low;
    input [7:0] high;
    begin
        divisor_is_zero = ({low, high} == `URX_DIV_ZERO);
    end
endfunction

// Trigger select decode
function [4:0] trig_of;
    input [1:0] sel;
    begin
        case (sel)
            2'd0:    trig_of = `URX_TRIG_1;
            2'd1:    trig_of = `URX_TRIG_4;
            2'd2:    trig_of = `URX_TRIG_8;
            default: trig_of = `URX_TRIG_14;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
reg  [7:0]       irqMask;
reg  [7:0]       fifoCtrl;
reg  [7:0]       scratch;
reg  [7:0]       resumeOne;
reg  [7:0]       resumeTwo;
reg  [7:0]       pauseOne;
reg  [7:0]       pauseTwo;
reg  [7:0]       sourceReg;
reg              dataReady;
reg  [7:0]       buf0;
reg  [7:0]       buf1;
reg  [1:0]       bufCount;
reg  [7:0]       fifoMem [0:DEPTH-1];
reg  [CNT_W-1:0] fifoCount;
reg  [CNT_W-2:0] wrPtr;
reg  [CNT_W-2:0] rdPtr;
reg  [4:0]       trigLevel;
reg  [7:0]       next_source;
wire             keyMode  = (lineFormat == `URX_ENH_KEY);
wire             divMode  = lineFormat[`URX_FMT_DIVEN];
wire             enhOn    = enhancedFeature[`URX_EFR_ENH];
wire             doWr     = cs & wr;
wire             doRd     = cs & rd;
wire             fifoOn   = fifoCtrl[`URX_FCR_RXEN];
wire             bufOut   = (bufCount != 2'd0);
wire             fifoFull = (fifoCount == DEPTH_C);
wire             popData  = doRd & ~divMode & (addr == `URX_A_DATA) & (fifoCount != 0);
wire             pushData = bufOut & ~fifoFull;
wire             rxReset  = doWr & ~keyMode & (addr == `URX_A_SRC) & wdata[`URX_FCR_RXRST];
// Both sides widened to the same width so neither count nor level is cut
wire             trigHit  = ({5'h00, fifoCount} >= {{CNT_W{1'b0}}, trigLevel});
wire             rxIrq    = fifoOn ? trigHit : (fifoCount != 0);

// Two-entry skid buffer: the FIFO stalls it when full, and it stalls the receiver
// A character offered in the cycle the buffer fills lands in the second entry,
// so a stall never drops a word
assign rxReady = (bufCount != 2'd2);

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        bufCount <= 2'd0;
        buf0     <= `URX_RESET_BYTE;
        buf1     <= `URX_RESET_BYTE;
    end else begin
        case ({rxValid & rxReady, pushData})
            2'b10: begin
                if (bufCount == 2'd0) begin
                    buf0 <= rxChar;
                end else begin
                    buf1 <= rxChar;
                end
                bufCount <= bufCount + 2'd1;
            end
            2'b01: begin
                buf0     <= buf1;
                bufCount <= bufCount - 2'd1;
            end
            2'b11: begin
                if (bufCount == 2'd1) begin
                    buf0 <= rxChar;
                end else begin
                    buf0 <= buf1;
                    buf1 <= rxChar;
                end
            end
            default: begin
                bufCount <= bufCount;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Receive FIFO
// Storage has no reset: it is only read behind a nonzero count
always @(posedge clk) begin
    if (pushData) fifoMem[wrPtr] <= buf0;
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        fifoCount <= {CNT_W{1'b0}};
        wrPtr     <= {(CNT_W-1){1'b0}};
        rdPtr     <= {(CNT_W-1){1'b0}};
        dataReady <= 1'b0;
    end else if (rxReset) begin
        fifoCount <= {CNT_W{1'b0}};
        wrPtr     <= {(CNT_W-1){1'b0}};
        rdPtr     <= {(CNT_W-1){1'b0}};
        dataReady <= 1'b0;
    end else begin
        if (pushData) begin
            wrPtr <= wrPtr + 1'b1;
        end
        if (popData) begin
            rdPtr <= rdPtr + 1'b1;
        end
        fifoCount <= fifoCount + {{(CNT_W-1){1'b0}}, pushData}
                               - {{(CNT_W-1){1'b0}}, popData};
        // Set wins: a push in the same cycle as the last pop keeps it high
        if (pushData) begin
            dataReady <= 1'b1;
        end else if (popData && fifoCount == {{(CNT_W-1){1'b0}}, 1'b1}) begin
            dataReady <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Trigger level select from FIFO control bits 7:6, the same in every mode
always @* begin
    trigLevel = trig_of(fifoCtrl[7:6]);
end

// Priority: line, rx data, tx empty, modem
// Only the highest pending cause is coded; lower ones wait their turn
always @* begin
    next_source = `URX_SRC_NONE;
    if (irqMask[`URX_MASK_MODEM] && modemStatus[3:0] != `URX_NIBBLE_ZERO)
        next_source = `URX_SRC_MODEM;
    if (irqMask[`URX_MASK_TX] && txEmpty)
        next_source = `URX_SRC_TX;
    // Level-driven: with FIFO on, appears at trigger and drops with fill below it; with FIFO off, set while any data
    if (irqMask[`URX_MASK_RX] && rxIrq)
        next_source = `URX_SRC_RXDATA;
    if (irqMask[`URX_MASK_LINE] && lineEvent)
        next_source = `URX_SRC_LINE;
    if (fifoOn)
        next_source = next_source | `URX_SRC_FIFO_ON;
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) sourceReg <= `URX_SRC_NONE;
    else sourceReg <= next_source;
end

// Output and source bit share one register, so they clear together
assign irq = ~sourceReg[0];

////////////////////////////////////////////////////////////////////////////////
// Register writes
// Gated writes are dropped silently; the host sees no error
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        irqMask         <= `URX_RESET_BYTE;
        fifoCtrl        <= `URX_RESET_BYTE;
        lineFormat      <= `URX_RESET_BYTE;
        modemCtrl       <= `URX_RESET_BYTE;
        scratch         <= `URX_RESET_BYTE;
        divisorLow      <= `URX_RESET_BYTE;
        divisorHigh     <= `URX_RESET_BYTE;
        divisorFraction <= `URX_RESET_BYTE;
        enhancedFeature <= `URX_RESET_BYTE;
        resumeOne       <= `URX_RESET_BYTE;
        resumeTwo       <= `URX_RESET_BYTE;
        pauseOne        <= `URX_RESET_BYTE;
        pauseTwo        <= `URX_RESET_BYTE;
    end else if (doWr) begin
        case (addr)
            `URX_A_DATA: begin
                if (divMode && !keyMode) divisorLow <= wdata;
            end
            `URX_A_MASK: begin
                if (!divMode)
                    irqMask <= enhOn ? wdata : (wdata & `URX_LOW_NIBBLE);
                else if (!keyMode) divisorHigh <= wdata;
            end
            `URX_A_SRC: begin
                if (keyMode) enhancedFeature <= wdata;
                else if (divMode) begin
                    if (enhOn) divisorFraction <= wdata & `URX_DLD_MASK;
                end else
                    // Reset bits self-clear; tx trigger bits need enhanced mode
                    fifoCtrl <= enhOn ? (wdata & `URX_FCR_WR_ENH)
                                      : (wdata & `URX_FCR_WR_STD);
            end
            `URX_A_FMT: lineFormat <= wdata;
            `URX_A_MCTL: begin
                if (keyMode) resumeOne <= wdata;
                else if (enhOn) modemCtrl <= wdata;
                else begin
                    modemCtrl <= (modemCtrl & `URX_UPPER_MCTL) | (wdata & ~`URX_UPPER_MCTL);
                end
            end
            `URX_A_LINE: begin
                if (keyMode) resumeTwo <= wdata;
            end
            `URX_A_MODEM: begin
                if (keyMode) pauseOne <= wdata;
            end
            default: begin
                if (keyMode) pauseTwo <= wdata;
                else scratch <= wdata;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read data, registered; identity codes appear only with a zero divisor
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata <= `URX_RESET_BYTE;
    else if (doRd) begin
        case (addr)
            `URX_A_DATA: begin
                if (keyMode) rdata <= divisorLow;
                else if (divMode)
                    rdata <= divisor_is_zero(divisorLow, divisorHigh) ? REV_CODE : divisorLow;
                else rdata <= (fifoCount != 0) ? fifoMem[rdPtr] : `URX_RESET_BYTE;
            end
            `URX_A_MASK: begin
                if (!divMode) rdata <= irqMask;
                else if (!keyMode && divisor_is_zero(divisorLow, divisorHigh)) rdata <= DEV_ID;
                else rdata <= divisorHigh;
            end
            `URX_A_SRC: begin
                if (keyMode) rdata <= enhancedFeature;
                else if (divMode) rdata <= divisorFraction & `URX_DLD_MASK;
                else rdata <= enhOn ? sourceReg : (sourceReg & `URX_SRC_STD);
            end
            `URX_A_FMT:   rdata <= lineFormat;
            `URX_A_MCTL:  rdata <= keyMode ? resumeOne : modemCtrl;
            `URX_A_LINE:  rdata <= keyMode ? resumeTwo
                                    : {1'b0, txEmpty, txEmpty, `URX_NIBBLE_ZERO, dataReady};
            `URX_A_MODEM: rdata <= keyMode ? pauseOne : modemStatus;
            default:      rdata <= keyMode ? pauseTwo : scratch;
        endcase
    end
end
endmodule
`default_nettype wire

// *** bench/urx_rx_source.sv ***
// Receive character source standing in for the receive shift register
`default_nettype none
module urx_rx_source (
    input  wire logic       clk,
    input  wire logic       rxReady,
    output var  logic       rxValid,
    output var  logic [7:0] rxChar
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rxValid = 1'b0;
        rxChar = 8'hff;
    end
    // Each char is held until rxReady is seen or 300 cycles pass; idle data is inverted so it cannot be reused
    task automatic send(input int n, input logic [7:0] b);
        int k;
        @(negedge clk);
        for (int i = 0; i < n; i++) begin
            rxValid = 1'b1;
            rxChar = b + i[7:0];
            k = 0;
            while (rxReady !== 1'b1 && k < 300) begin
                @(negedge clk);
                k++;
            end
            @(negedge clk);
        end
        rxValid = 1'b0;
        rxChar = ~(b + n[7:0] - 8'h01);
    endtask
endmodule
`default_nettype wire

// *** bench/urx_regmap_asserts.sv ***
// Port-level assertions for the register map block
`default_nettype none
module urx_regmap_asserts (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [2:0] addr,
    input wire logic       cs,
    input wire logic       rd,
    input wire logic       wr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       irq,
    input wire logic [7:0] divisorHigh,
    input wire logic [7:0] divisorFraction,
    input wire logic [7:0] enhancedFeature,
    input wire logic [7:0] modemCtrl,
    input wire logic [7:0] lineFormat
);
    timeunit 1ns;
    timeprecision 1ns;
    logic maskTouched;
    wire  wrOk = cs && wr;
    wire  fmtKey = lineFormat == 8'hbf;
    // Until any mask write, no source may reach irq
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            maskTouched <= 1'b0;
        else if (wrOk && addr == 3'h1 && !lineFormat[7])
            maskTouched <= 1'b1;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_MASK_GATES: assert property (!maskTouched |-> !irq)
        else $error("irq raised with every source masked");
    AST_SRC_NONE: assert property ((cs && rd && addr == 3'h2 && !lineFormat[7]
        && !maskTouched) |=> rdata[5:0] == 6'h01) else $error("source read not idle");
    AST_FRAC_GATED: assert property ((wrOk && addr == 3'h2 && lineFormat[7] && !fmtKey
        && !enhancedFeature[4]) |=> $stable(divisorFraction)) else $error("fraction written");
    AST_FRAC_FIELDS: assert property ((wrOk && addr == 3'h2 && lineFormat[7] && !fmtKey
        && enhancedFeature[4]) |=> divisorFraction == ($past(wdata) & 8'h3f))
        else $error("fraction fields wrong");
    AST_MASK_NOT_DIV: assert property ((wrOk && addr == 3'h1 && !lineFormat[7])
        |=> $stable(divisorHigh)) else $error("mask write hit divisor");
    AST_FCR_NOT_ENH: assert property ((wrOk && addr == 3'h2 && !lineFormat[7])
        |=> $stable(enhancedFeature) && $stable(divisorFraction)) else $error("fifo write leaked");
    AST_LSR_RO: assert property ((wrOk && addr == 3'h5 && !fmtKey)
        |=> $stable(lineFormat) && $stable(modemCtrl)) else $error("line status written");
    AST_EFR_KEY: assert property ((wrOk && addr == 3'h2 && fmtKey)
        |=> enhancedFeature == $past(wdata)) else $error("enhanced register not written");
endmodule
bind urx_regmap urx_regmap_asserts chk (.clk, .rst_n, .addr, .cs, .rd, .wr, .wdata, .rdata,
    .irq, .divisorHigh, .divisorFraction, .enhancedFeature, .modemCtrl, .lineFormat);
`default_nettype wire

// *** bench/urx_regmap_tb.sv ***
// Self-checking bench for the register map block
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module urx_regmap_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rst_n, cs, rd, wr, txEmpty, lineEvent, rxValid, rxReady, irq;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, rxChar, modemStatus;
    int         failures = 0;
    int         checks = 0;
    urx_rx_source src (.clk, .rxReady, .rxValid, .rxChar);
    urx_regmap dut (.clk, .rst_n, .addr, .cs, .rd, .wr, .wdata, .rdata, .rxValid, .rxReady,
        .rxChar, .txEmpty, .lineEvent, .modemStatus, .irq, .divisorLow(), .divisorHigh(),
        .divisorFraction(), .enhancedFeature(), .modemCtrl(), .lineFormat());
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        {cs, wr, addr, wdata} = {2'b11, a, d};
        @(negedge clk);
        {cs, wr} = 2'b00;
    endtask
    task automatic rreg(input logic [2:0] a, input logic [7:0] e);
        @(negedge clk);
        {cs, rd, addr} = {2'b11, a};
        @(negedge clk);
        {cs, rd} = 2'b00;
        `CHK("rdata", e, rdata)
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        close_out;
    end
    initial begin
        {rst_n, cs, rd, wr, txEmpty, lineEvent} = 6'h00;
        addr = 3'h0;
        wdata = 8'h00;
        modemStatus = 8'h30;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        rreg(3'h2, 8'h01);
        rreg(3'h5, 8'h00);
        rreg(3'h6, 8'h30);
        wreg(3'h5, 8'hff);
        wreg(3'h7, 8'ha5);
        rreg(3'h7, 8'ha5);
        txEmpty = 1'b1;
        rreg(3'h5, 8'h60);
        txEmpty = 1'b0;
        // Divisor still zero, so its places read the arbitrary codes
        wreg(3'h3, 8'h80);
        rreg(3'h0, 8'h01);
        rreg(3'h1, 8'h5a);
        wreg(3'h0, 8'h12);
        rreg(3'h0, 8'h12);
        wreg(3'h2, 8'h3f);
        rreg(3'h2, 8'h00);
        wreg(3'h3, 8'hbf);
        wreg(3'h2, 8'h10);
        wreg(3'h7, 8'h13);
        rreg(3'h7, 8'h13);
        rreg(3'h2, 8'h10);
        wreg(3'h3, 8'h80);
        wreg(3'h2, 8'hff);
        rreg(3'h2, 8'h3f);
        wreg(3'h3, 8'h00);
        wreg(3'h1, 8'h01);
        wreg(3'h2, 8'h01);
        src.send(1, 8'h41);
        repeat (4) @(negedge clk);
        `CHK("irq", 1'b1, irq)
        rreg(3'h2, 8'hc4);
        rreg(3'h5, 8'h01);
        rreg(3'h0, 8'h41);
        repeat (4) @(negedge clk);
        `CHK("irq", 1'b0, irq)
        rreg(3'h2, 8'hc1);
        rreg(3'h5, 8'h00);
        wreg(3'h2, 8'h41);
        src.send(3, 8'h50);
        repeat (4) @(negedge clk);
        `CHK("irq", 1'b0, irq)
        src.send(1, 8'h53);
        repeat (4) @(negedge clk);
        `CHK("irq", 1'b1, irq)
        rreg(3'h0, 8'h50);
        repeat (4) @(negedge clk);
        `CHK("irq", 1'b0, irq)
        rreg(3'h5, 8'h01);
        wreg(3'h2, 8'h03);
        repeat (2) @(negedge clk);
        rreg(3'h5, 8'h00);
        // Fill FIFO and skid until the stream is refused, then drain in order
        fork
            src.send(20, 8'h80);
            begin
                repeat (40) @(negedge clk);
                `CHK("rxReady", 1'b0, rxReady)
                for (int i = 0; i < 20; i++)
                    rreg(3'h0, 8'h80 + i[7:0]);
            end
        join
        repeat (4) @(negedge clk);
        rreg(3'h5, 8'h00);
        // Every other cause pending at once; the mask alone decides what shows
        {txEmpty, lineEvent, modemStatus} = {2'b11, 8'h31};
        wreg(3'h1, 8'h00);
        repeat (2) @(negedge clk);
        `CHK("irq", 1'b0, irq)
        wreg(3'h1, 8'h08);
        rreg(3'h2, 8'hc0);
        wreg(3'h1, 8'h02);
        rreg(3'h2, 8'hc2);
        wreg(3'h1, 8'h0c);
        rreg(3'h2, 8'hc6);
        `CHK("irq", 1'b1, irq)
        close_out;
    end
endmodule
`default_nettype wire
